// ---- core/pmlb_top.sv ----
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module pmlb_top #(
    parameter int unsigned TICK_CYCLES = pmlb_pkg::TICK_CYCLES_DFLT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // optical ports
    input wire logic [3:0] sig_present,
    input wire logic [3:0] port_ok,
    input wire logic [3:0] rx_data,
    input wire logic [3:0] norm_tx,
    output logic [3:0] tx_data,
    // board monitor and backup
    input wire logic over_temp,
    output logic over_temp_evt,
    output logic link_b_active
);
    // ---------------- register bus ----------------
    logic aw_ff, nxt_aw, w_ff, nxt_w, bvalid_ff, nxt_bvalid;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic wr_go;
    logic [31:0] wmask, wval;
    logic [31:0] cmd;

    // ---------------- shared state ----------------
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick_ff, nxt_tick;
    logic [31:0] uptime_ff, nxt_uptime, since_ff, nxt_since;
    logic ot_s1_ff, ot_s2_ff, ot_prev_ff;
    logic ot_flag_ff, nxt_ot_flag, ot_evt_ff, nxt_ot_evt;
    logic ok_s1_a_ff, ok_a_ff, ok_s1_b_ff, ok_b_ff;
    logic on_b_ff, nxt_on_b, manual_ff, nxt_manual;
    logic [31:0] bcount_ff, nxt_bcount, bdur_ff, nxt_bdur;
    logic clr_stats, man_allowed;
    logic [3:0] looped, sig_now;
    pmlb_pkg::pmlb_stats_t stats [pmlb_pkg::NUM_PORTS];

    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign wr_go = aw_ff && w_ff && !bvalid_ff;
    assign wmask = pmlb_pkg::strb_mask(wstrb_ff);
    assign wval = wdata_ff & wmask;
    assign cmd = (wr_go && awaddr_ff == pmlb_pkg::REG_CMD) ? wval : '0;
    assign clr_stats = cmd[pmlb_pkg::CMD_CLR_STATS];

    // write side: address and data are taken in either order
    always_comb begin
        nxt_aw = aw_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w = w_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_ctrl = ctrl_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = pmlb_pkg::RESP_OKAY;
            if (awaddr_ff == pmlb_pkg::REG_CTRL) begin
                nxt_ctrl = ((ctrl_ff & ~wmask) | wval) & pmlb_pkg::CTRL_MASK;
            end else if (awaddr_ff == pmlb_pkg::REG_CMD) begin
                nxt_bresp = pmlb_pkg::RESP_OKAY;
            end else if (awaddr_ff == pmlb_pkg::REG_STATUS) begin
                nxt_bresp = pmlb_pkg::RESP_OKAY;
            end else begin
                nxt_bresp = pmlb_pkg::RESP_SLVERR;
            end
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // read side: one-cycle registered answer
    always_comb begin
        logic [7:0] rel;
        logic [1:0] pidx;
        rel = s_axi_araddr - pmlb_pkg::REG_PORT_BASE;
        pidx = rel[5:4];
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = pmlb_pkg::RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (s_axi_araddr == pmlb_pkg::REG_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (s_axi_araddr == pmlb_pkg::REG_CMD) begin
                nxt_rdata = 32'h0000_0000;
            end else if (s_axi_araddr == pmlb_pkg::REG_STATUS) begin
                nxt_rdata[pmlb_pkg::ST_LOOPED_LSB +: 4] = looped;
                nxt_rdata[pmlb_pkg::ST_ON_B] = on_b_ff;
                nxt_rdata[pmlb_pkg::ST_MANUAL] = manual_ff;
                nxt_rdata[pmlb_pkg::ST_OVER_TEMP] = ot_flag_ff;
                nxt_rdata[pmlb_pkg::ST_SIG_LSB +: 4] = sig_now;
                nxt_rdata[pmlb_pkg::ST_LINK_A_OK] = ok_a_ff;
                nxt_rdata[pmlb_pkg::ST_LINK_B_OK] = ok_b_ff;
            end else if (s_axi_araddr == pmlb_pkg::REG_UPTIME) begin
                nxt_rdata = uptime_ff;
            end else if (s_axi_araddr == pmlb_pkg::REG_SINCE_CLR) begin
                nxt_rdata = since_ff;
            end else if (s_axi_araddr == pmlb_pkg::REG_BKP_COUNT) begin
                nxt_rdata = bcount_ff;
            end else if (s_axi_araddr == pmlb_pkg::REG_BKP_DUR) begin
                nxt_rdata = bdur_ff;
            end else if (s_axi_araddr >= pmlb_pkg::REG_PORT_BASE &&
                    rel < 8'h40 && rel[3:0] == pmlb_pkg::PORT_OFS_CHANGE[3:0]) begin
                nxt_rdata = stats[pidx].change_s;
            end else if (s_axi_araddr >= pmlb_pkg::REG_PORT_BASE &&
                    rel < 8'h40 && rel[3:0] == pmlb_pkg::PORT_OFS_LOSS_CNT[3:0]) begin
                nxt_rdata = stats[pidx].loss_cnt;
            end else if (s_axi_araddr >= pmlb_pkg::REG_PORT_BASE &&
                    rel < 8'h40 && rel[3:0] == pmlb_pkg::PORT_OFS_LOSS_TIME[3:0]) begin
                nxt_rdata = stats[pidx].loss_s;
            end else begin
                nxt_rresp = pmlb_pkg::RESP_SLVERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // one-second tick, uptime and over-temperature
    always_comb begin
        nxt_tick = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 32'h0000_0001;
        if (tick_cnt_ff >= TICK_CYCLES - 1) begin
            nxt_tick_cnt = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
        nxt_uptime = tick_ff ? uptime_ff + 32'h0000_0001 : uptime_ff;
        nxt_since = tick_ff ? since_ff + 32'h0000_0001 : since_ff;
        if (clr_stats) begin
            nxt_since = 32'h0000_0000;
        end
        nxt_ot_evt = ot_s2_ff && !ot_prev_ff;
        nxt_ot_flag = ot_flag_ff;
        if (wr_go && awaddr_ff == pmlb_pkg::REG_STATUS &&
                wval[pmlb_pkg::ST_OVER_TEMP]) begin
            nxt_ot_flag = 1'b0;
        end
        // a new event in the clearing cycle is kept
        if (nxt_ot_evt) begin
            nxt_ot_flag = 1'b1;
        end
    end

    // link selection between port 3 and port 4
    assign man_allowed = (ok_a_ff && ok_b_ff) ||
        (ctrl_ff[pmlb_pkg::CTRL_ALLOW_FAIL] && cmd[pmlb_pkg::CMD_FORCE]);

    always_comb begin
        nxt_on_b = on_b_ff;
        nxt_manual = manual_ff;
        if ((cmd[pmlb_pkg::CMD_SWITCH_A] || cmd[pmlb_pkg::CMD_SWITCH_B])) begin
            if (man_allowed) begin
                nxt_on_b = cmd[pmlb_pkg::CMD_SWITCH_B];
                nxt_manual = 1'b1;
            end
        end else if (!ctrl_ff[pmlb_pkg::CTRL_AUTO_DIS]) begin
            // manual choice is not undone by automatic switch-back
            if (!on_b_ff && !ok_a_ff && ok_b_ff) begin
                nxt_on_b = 1'b1;
                nxt_manual = 1'b0;
            end else if (on_b_ff && ok_a_ff && !manual_ff) begin
                nxt_on_b = 1'b0;
            end
        end
        nxt_bcount = bcount_ff;
        nxt_bdur = bdur_ff;
        if (nxt_on_b && !on_b_ff) begin
            nxt_bcount = bcount_ff + 32'h0000_0001;
            nxt_bdur = 32'h0000_0000;
        end else if (on_b_ff && tick_ff) begin
            nxt_bdur = bdur_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            w_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= pmlb_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= pmlb_pkg::RESP_OKAY;
            ctrl_ff <= pmlb_pkg::CTRL_RESET;
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
            uptime_ff <= 32'h0000_0000;
            since_ff <= 32'h0000_0000;
            ot_s1_ff <= 1'b0;
            ot_s2_ff <= 1'b0;
            ot_prev_ff <= 1'b0;
            ot_flag_ff <= 1'b0;
            ot_evt_ff <= 1'b0;
            ok_s1_a_ff <= 1'b0;
            ok_a_ff <= 1'b0;
            ok_s1_b_ff <= 1'b0;
            ok_b_ff <= 1'b0;
            on_b_ff <= 1'b0;
            manual_ff <= 1'b0;
            bcount_ff <= 32'h0000_0000;
            bdur_ff <= 32'h0000_0000;
        end else begin
            aw_ff <= nxt_aw;
            awaddr_ff <= nxt_awaddr;
            w_ff <= nxt_w;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
            uptime_ff <= nxt_uptime;
            since_ff <= nxt_since;
            ot_s1_ff <= over_temp;
            ot_s2_ff <= ot_s1_ff;
            ot_prev_ff <= ot_s2_ff;
            ot_flag_ff <= nxt_ot_flag;
            ot_evt_ff <= nxt_ot_evt;
            ok_s1_a_ff <= port_ok[pmlb_pkg::LINK_A_IDX];
            ok_a_ff <= ok_s1_a_ff;
            ok_s1_b_ff <= port_ok[pmlb_pkg::LINK_B_IDX];
            ok_b_ff <= ok_s1_b_ff;
            on_b_ff <= nxt_on_b;
            manual_ff <= nxt_manual;
            bcount_ff <= nxt_bcount;
            bdur_ff <= nxt_bdur;
        end
    end

    // one independent monitor per port
    for (genvar p = 0; p < pmlb_pkg::NUM_PORTS; p++) begin : g_port
        pmlb_port u_port (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick_ff),
            .clear(clr_stats),
            .engage(cmd[pmlb_pkg::CMD_ENGAGE_LSB + p]),
            .disengage(cmd[pmlb_pkg::CMD_DISENGAGE_LSB + p]),
            .tmo_sel(ctrl_ff[pmlb_pkg::CTRL_TMO_LSB + 2 * p +: 2]),
            .sig_pin(sig_present[p]),
            .rx_pin(rx_data[p]),
            .norm_tx(norm_tx[p]),
            .tx_out(tx_data[p]),
            .looped(looped[p]),
            .sig_now(sig_now[p]),
            .stats(stats[p])
        );
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign over_temp_evt = ot_evt_ff;
    assign link_b_active = on_b_ff;
endmodule
`default_nettype wire

// ---- common/pmlb_pkg.sv ----
`default_nettype none
package pmlb_pkg;
    localparam int unsigned NUM_PORTS = 4;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ * TICK_PERIOD_S;

    // loopback timeout choices, in seconds
    localparam logic [1:0] TMO_NONE = 2'h0;
    localparam logic [1:0] TMO_10S = 2'h1;
    localparam logic [1:0] TMO_30S = 2'h2;
    localparam logic [1:0] TMO_5MIN = 2'h3;
    localparam logic [8:0] TMO_10S_SECS = 9'h00A;
    localparam logic [8:0] TMO_30S_SECS = 9'h01E;
    localparam logic [8:0] TMO_5MIN_SECS = 9'h12C;

    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_UPTIME = 8'h0C;
    localparam logic [7:0] REG_SINCE_CLR = 8'h10;
    localparam logic [7:0] REG_BKP_COUNT = 8'h14;
    localparam logic [7:0] REG_BKP_DUR = 8'h18;
    localparam logic [7:0] REG_PORT_BASE = 8'h20;
    localparam logic [7:0] REG_PORT_STRIDE = 8'h10;
    localparam logic [7:0] PORT_OFS_CHANGE = 8'h00;
    localparam logic [7:0] PORT_OFS_LOSS_CNT = 8'h04;
    localparam logic [7:0] PORT_OFS_LOSS_TIME = 8'h08;

    // control register fields
    localparam int unsigned CTRL_AUTO_DIS = 0;
    localparam int unsigned CTRL_ALLOW_FAIL = 1;
    localparam int unsigned CTRL_TMO_LSB = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_03FF;

    // command register fields (write-only pulses)
    localparam int unsigned CMD_ENGAGE_LSB = 0;
    localparam int unsigned CMD_DISENGAGE_LSB = 4;
    localparam int unsigned CMD_CLR_STATS = 8;
    localparam int unsigned CMD_SWITCH_A = 9;
    localparam int unsigned CMD_SWITCH_B = 10;
    localparam int unsigned CMD_FORCE = 11;

    // status register fields
    localparam int unsigned ST_LOOPED_LSB = 0;
    localparam int unsigned ST_ON_B = 4;
    localparam int unsigned ST_MANUAL = 5;
    localparam int unsigned ST_OVER_TEMP = 6;
    localparam int unsigned ST_SIG_LSB = 7;
    localparam int unsigned ST_LINK_A_OK = 11;
    localparam int unsigned ST_LINK_B_OK = 12;

    // data links: port 3 is link A, port 4 is link B
    localparam int unsigned LINK_A_IDX = 2;
    localparam int unsigned LINK_B_IDX = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] change_s;
        logic [31:0] loss_cnt;
        logic [31:0] loss_s;
    } pmlb_stats_t;

    function automatic logic [8:0] tmo_secs(input logic [1:0] sel);
        case (sel)
            TMO_10S: tmo_secs = TMO_10S_SECS;
            TMO_30S: tmo_secs = TMO_30S_SECS;
            TMO_5MIN: tmo_secs = TMO_5MIN_SECS;
            default: tmo_secs = 9'h000;
        endcase
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
endpackage
`default_nettype wire

// ---- core/pmlb_port.sv ----
`default_nettype none
module pmlb_port (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // timing and commands
    input wire logic tick,
    input wire logic clear,
    input wire logic engage,
    input wire logic disengage,
    input wire logic [1:0] tmo_sel,
    // optical side
    input wire logic sig_pin,
    input wire logic rx_pin,
    input wire logic norm_tx,
    output logic tx_out,
    // status
    output logic looped,
    output logic sig_now,
    output pmlb_pkg::pmlb_stats_t stats
);
    logic sig_s1_ff, sig_s2_ff, sig_prev_ff;
    logic rx_s1_ff, rx_s2_ff, tx_ff, nxt_tx;
    logic loop_ff, nxt_loop;
    logic [8:0] lim_ff, nxt_lim, cnt_ff, nxt_cnt;
    pmlb_pkg::pmlb_stats_t stats_ff, nxt_stats;
    logic change;

    assign change = sig_s2_ff ^ sig_prev_ff;

    always_comb begin
        nxt_stats = stats_ff;
        if (change) begin
            nxt_stats.change_s = 32'h0000_0000;
            nxt_stats.loss_cnt = stats_ff.loss_cnt + 32'h0000_0001;
        end else if (tick) begin
            nxt_stats.change_s = stats_ff.change_s + 32'h0000_0001;
        end
        if (tick && !sig_prev_ff) begin
            nxt_stats.loss_s = stats_ff.loss_s + 32'h0000_0001;
        end
        if (clear) begin
            nxt_stats = '0;
        end
    end

    always_comb begin
        nxt_loop = loop_ff;
        nxt_lim = lim_ff;
        nxt_cnt = cnt_ff;
        if (engage && !loop_ff) begin
            nxt_loop = 1'b1;
            nxt_lim = pmlb_pkg::tmo_secs(tmo_sel);
            nxt_cnt = 9'h000;
        end else if (loop_ff && lim_ff != 9'h000 && tick) begin
            nxt_cnt = cnt_ff + 9'h001;
            if (nxt_cnt >= lim_ff) begin
                nxt_loop = 1'b0;
            end
        end
        // disengage wins over a same-write engage
        if (disengage) begin
            nxt_loop = 1'b0;
        end
        nxt_tx = loop_ff ? rx_s2_ff : norm_tx;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sig_s1_ff <= 1'b0;
            sig_s2_ff <= 1'b0;
            sig_prev_ff <= 1'b0;
            rx_s1_ff <= 1'b0;
            rx_s2_ff <= 1'b0;
            tx_ff <= 1'b0;
            loop_ff <= 1'b0;
            lim_ff <= 9'h000;
            cnt_ff <= 9'h000;
            stats_ff <= '0;
        end else begin
            sig_s1_ff <= sig_pin;
            sig_s2_ff <= sig_s1_ff;
            sig_prev_ff <= sig_s2_ff;
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
            tx_ff <= nxt_tx;
            loop_ff <= nxt_loop;
            lim_ff <= nxt_lim;
            cnt_ff <= nxt_cnt;
            stats_ff <= nxt_stats;
        end
    end

    assign tx_out = tx_ff;
    assign looped = loop_ff;
    assign sig_now = sig_prev_ff;
    assign stats = stats_ff;
endmodule
`default_nettype wire

// ---- verification/pmlb_top_properties.sv ----
`default_nettype none
module pmlb_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // board monitor
    input wire logic over_temp,
    input wire logic over_temp_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_wr_answer: assert property (s_wr_taken |=> s_b_answer)
        else $error("write response not on time");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data not on time");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_w_block: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_temp_event: assert property ($rose(over_temp) |-> ##[2:4] over_temp_evt)
        else $error("over-temperature event missing");
    a_temp_pulse: assert property (over_temp_evt |=> !over_temp_evt)
        else $error("over-temperature event too long");
endmodule

bind pmlb_top pmlb_props u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .over_temp(over_temp), .over_temp_evt(over_temp_evt)
);
`default_nettype wire

// ---- verification/pmlb_mgr.sv ----
`default_nettype none
module pmlb_mgr (
    // clock
    input wire logic aclk,
    // write channels
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read channels
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end
    // each half released on its own ready; response awaited after both
    task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                      output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, dt, 4'hF};
        {awvalid, wvalid} <= 2'h3;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dt,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verification/test_pmlb_top.sv ----
`default_nettype none
module test_pmlb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 10;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ot, ote, lb;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, sig, ok, rx, ntx, tx;
    logic [1:0] bresp, rresp, r;
    int failures, samples_checked, cyc, s;

    pmlb_top #(.TICK_CYCLES(TC)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .sig_present(sig), .port_ok(ok), .rx_data(rx), .norm_tx(ntx),
        .tx_data(tx), .over_temp(ot), .over_temp_evt(ote),
        .link_b_active(lb));
    pmlb_mgr mgr (.aclk(aclk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // ranges absorb tick phase against bus latency
    task automatic cmpr(input logic [31:0] g, input logic [31:0] lo,
                        input logic [31:0] hi);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        mgr.wr(a, dt, r);
    endtask
    task automatic rd(input logic [7:0] a);
        mgr.rd(a, d, r);
    endtask
    task automatic tk(input int n);
        repeat (n * TC) @(posedge aclk);
    endtask
    function automatic logic [7:0] pa(input int k, input logic [7:0] o);
        pa = 8'(pmlb_pkg::REG_PORT_BASE + pmlb_pkg::REG_PORT_STRIDE * k + o);
    endfunction

    initial begin
        {aresetn, ot, sig, rx, ntx} = 14'h0;
        ok = 4'hF;
        {failures, samples_checked, cyc} = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pmlb_pkg::REG_CTRL);
        cmp(d, pmlb_pkg::CTRL_RESET);
        wr(8'hFC, 32'h1);
        cmp(32'(r), 32'(pmlb_pkg::RESP_SLVERR));
        rd(8'hFC);
        cmp(d, 32'h0);
        cmp(32'(r), 32'(pmlb_pkg::RESP_SLVERR));
        wr(pmlb_pkg::REG_CMD, 32'h100);
        sig <= 4'hF;
        tk(3);
        for (int k = 0; k < 4; k++) begin
            rd(pa(k, pmlb_pkg::PORT_OFS_LOSS_CNT));
            cmp(d, 32'h1);
        end
        sig <= 4'hE;
        tk(5);
        sig <= 4'hF;
        tk(2);
        rd(pa(0, pmlb_pkg::PORT_OFS_LOSS_TIME));
        cmpr(d, 32'h4, 32'h7);
        rd(pa(0, pmlb_pkg::PORT_OFS_CHANGE));
        cmpr(d, 32'h1, 32'h3);
        rd(pa(0, pmlb_pkg::PORT_OFS_LOSS_CNT));
        cmp(d, 32'h3);
        rd(pa(1, pmlb_pkg::PORT_OFS_LOSS_TIME));
        cmpr(d, 32'h0, 32'h1);
        wr(pmlb_pkg::REG_CMD, 32'h100);
        rd(pa(0, pmlb_pkg::PORT_OFS_LOSS_CNT));
        cmp(d, 32'h0);
        rd(pmlb_pkg::REG_SINCE_CLR);
        cmpr(d, 32'h0, 32'h1);
        rd(pmlb_pkg::REG_UPTIME);
        cmpr(d, 32'hA, 32'h12);
        rx <= 4'h2;
        ntx <= 4'h1;
        wr(pmlb_pkg::REG_CMD, 32'h2);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'(d[1]), 32'h1);
        tk(1);
        cmp(32'(tx), 32'h3);
        wr(pmlb_pkg::REG_CMD, 32'h20);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'(d[1]), 32'h0);
        tk(1);
        cmp(32'(tx), 32'h1);
        for (int k = 1; k < 4; k++) begin
            s = (k == 1) ? 10 : (k == 2) ? 30 : 300;
            wr(pmlb_pkg::REG_CTRL, 32'(k) << 6);
            wr(pmlb_pkg::REG_CMD, 32'h4);
            tk(s - 2);
            rd(pmlb_pkg::REG_STATUS);
            cmp(32'(d[2]), 32'h1);
            tk(4);
            rd(pmlb_pkg::REG_STATUS);
            cmp(32'(d[2]), 32'h0);
        end
        ot <= 1'b1;
        tk(1);
        ot <= 1'b0;
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'(d[6]), 32'h1);
        wr(pmlb_pkg::REG_STATUS, 32'h40);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'({d[6], d[5], d[4], lb}), 32'h0);
        wr(pmlb_pkg::REG_CMD, 32'h400);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'({d[5], d[4], lb}), 32'h7);
        tk(5);
        rd(pmlb_pkg::REG_BKP_DUR);
        cmpr(d, 32'h4, 32'h6);
        wr(pmlb_pkg::REG_CMD, 32'h200);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'({d[4], lb}), 32'h0);
        wr(pmlb_pkg::REG_CTRL, 32'h1);
        ok <= 4'hB;
        tk(1);
        wr(pmlb_pkg::REG_CMD, 32'h400);
        wr(pmlb_pkg::REG_CMD, 32'hC00);
        cmp(32'(lb), 32'h0);
        wr(pmlb_pkg::REG_CTRL, 32'h3);
        wr(pmlb_pkg::REG_CMD, 32'hC00);
        rd(pmlb_pkg::REG_BKP_COUNT);
        cmp(d, 32'h2);
        cmp(32'(lb), 32'h1);
        wr(pmlb_pkg::REG_CMD, 32'hA00);
        wr(pmlb_pkg::REG_CTRL, 32'h2);
        rd(pmlb_pkg::REG_STATUS);
        cmp(32'({d[5], d[4], lb}), 32'h3);
        results();
    end
endmodule
`default_nettype wire
